// ---- hdl/pdc_pkg.sv ----
// pdc_pkg: constants, command and state enumerations and the command decoder
// for the power-state and clock-management tracker.
// assumes: one 20 MHz clock; all times below are converted to whole cycles here.
package pdc_pkg;

	// ==========================================================================
	// clock and counter sizes
	localparam int CLK_PERIOD_NS = 50;
	localparam int CNT_W         = 8;
	localparam int CMD_W         = 4;
	localparam int LAT_W         = 4;
	localparam int BURST_W       = 5;

	// ==========================================================================
	// timing figures in their own units (plain defaults where none is given)
	localparam int STROBE_ACCESS_MAX_NS = 6;
	localparam int WRITE_RECOVERY_NS    = 15;
	localparam int CLK_EN_HOLD_NS       = 1;
	localparam int POWERDOWN_EXIT_NS    = 8;
	localparam int MODE_WRITE_DELAY_TCK = 5;
	localparam int CLOCK_SETTLE_TCK     = 2;

	// least time to whole cycles, rounded up, never below one
	function automatic int ceil_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : ceil_cyc

	localparam logic [CNT_W-1:0] STROBE_ACCESS_CYC = CNT_W'(ceil_cyc(STROBE_ACCESS_MAX_NS));
	localparam logic [CNT_W-1:0] WRITE_RECOVERY_CYC = CNT_W'(ceil_cyc(WRITE_RECOVERY_NS));
	localparam logic [CNT_W-1:0] CLK_EN_HOLD_CYC    = CNT_W'(ceil_cyc(CLK_EN_HOLD_NS));
	localparam logic [CNT_W-1:0] POWERDOWN_EXIT_CYC = CNT_W'(ceil_cyc(POWERDOWN_EXIT_NS));
	localparam logic [CNT_W-1:0] MODE_WRITE_CYC     = CNT_W'(MODE_WRITE_DELAY_TCK);
	localparam logic [CNT_W-1:0] CLOCK_SETTLE_CYC   = CNT_W'(CLOCK_SETTLE_TCK);
	localparam logic [CNT_W-1:0] RESTART_CYC        = CNT_W'(CLOCK_SETTLE_TCK
	                                                  + ceil_cyc(POWERDOWN_EXIT_NS));
	localparam logic [CNT_W-1:0] EXTRA_CYC          = 8'h01;

	// ==========================================================================
	// reset values
	localparam logic CKE_PREV_RST      = 1'b0;
	localparam logic INIT_REQUIRED_RST = 1'b1;
	localparam logic DATA_LOST_RST     = 1'b1;
	localparam logic ILLEGAL_RST       = 1'b0;

	// ==========================================================================
	// enumerations
	typedef enum logic [3:0] {
		cmd_nop, cmd_hold, cmd_mrw, cmd_mrr, cmd_ref_one, cmd_ref_all, cmd_act,
		cmd_wr, cmd_rd, cmd_pre, cmd_bst, cmd_pd_entry, cmd_sref_entry,
		cmd_dpd_entry, cmd_exit, cmd_bad
	} pdc_cmd_type;

	typedef enum logic [1:0] {
		st_normal, st_power_down, st_deep_sleep, st_wait_ready
	} pdc_state_type;

	// ==========================================================================
	// command decode from clock enable of two edges, chip select and low bits
	function automatic pdc_cmd_type pdc_decode(input logic             cke_prev,
	                                           input logic             cke_now,
	                                           input logic             cs_n,
	                                           input logic [CMD_W-1:0] cmd);
		pdc_cmd_type c;
		c = cmd_bad;
		if (cke_prev && cke_now) begin
			if (cs_n) begin
				c = cmd_nop;
			end else begin
				case (cmd[2:0])
					3'h0: c = cmd[3] ? cmd_mrr : cmd_mrw;
					3'h4: c = cmd[3] ? cmd_ref_all : cmd_ref_one;
					3'h2, 3'h6: c = cmd_act;
					3'h1: c = cmd_wr;
					3'h5: c = cmd_rd;
					3'h3: c = cmd[3] ? cmd_pre : cmd_bst;
					3'h7: c = cmd_nop;
					default: c = cmd_bad;
				endcase
			end
		end else if (cke_prev) begin
			if (cs_n) begin
				c = cmd_pd_entry;
			end else if (cmd[2:0] == 3'h3) begin
				c = cmd_dpd_entry;
			end else if (cmd[2:0] == 3'h4) begin
				c = cmd_sref_entry;
			end else begin
				c = cmd_bad;
			end
		end else if (cke_now) begin
			c = cmd_exit;
		end else begin
			c = cmd_hold;
		end
		return c;
	endfunction : pdc_decode

endpackage : pdc_pkg

// ---- hdl/pdc_guard_if.sv ----
// pdc_guard_if: carries delay loads from the tracker to the clock-enable guard
// and the guard's busy levels back.
// assumes: both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface pdc_guard_if;
	logic                       load;
	logic [pdc_pkg::CNT_W-1:0]  load_value;
	logic                       burst_load;
	logic [pdc_pkg::CNT_W-1:0]  burst_value;
	logic                       hold_busy;
	logic                       burst_busy;

	modport ctl   (output load, load_value, burst_load, burst_value,
	               input hold_busy, burst_busy);
	modport guard (input load, load_value, burst_load, burst_value,
	               output hold_busy, burst_busy);
endinterface : pdc_guard_if
`default_nettype wire

// ---- hdl/pdc_cke_guard.sv ----
// pdc_cke_guard: counts down the longest outstanding command-to-clock-enable-low
// delay and the data burst still on the bus.
// assumes: loads arrive as one-cycle pulses on the clock edge of the command.
`timescale 1ns/100ps
`default_nettype none
module pdc_cke_guard (
	input  wire logic      ref_clk_i,
	input  wire logic      resetn_i,
	pdc_guard_if.guard     g
);
	import pdc_pkg::*;

	logic [CNT_W-1:0] hold_cnt;
	logic [CNT_W-1:0] next_hold_cnt;
	logic [CNT_W-1:0] burst_cnt;
	logic [CNT_W-1:0] next_burst_cnt;

	// ==========================================================================
	// countdown; a newer shorter delay never cuts an older longer one
	always_comb begin
		next_hold_cnt = (hold_cnt != '0) ? hold_cnt - 8'h01 : '0;
		if (g.load && (g.load_value > next_hold_cnt)) begin
			next_hold_cnt = g.load_value;
		end
		// idle cycles only count down, so a no-op never ends a burst early
		next_burst_cnt = (burst_cnt != '0) ? burst_cnt - 8'h01 : '0;
		if (g.burst_load && (g.burst_value > next_burst_cnt)) begin
			next_burst_cnt = g.burst_value;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			hold_cnt  <= '0;
			burst_cnt <= '0;
		end else begin
			hold_cnt  <= next_hold_cnt;
			burst_cnt <= next_burst_cnt;
		end
	end

	// clock enable may be sampled low once one cycle or less remains
	assign g.hold_busy  = (hold_cnt > 8'h01);
	assign g.burst_busy = (burst_cnt != '0);

	// ==========================================================================
	// checks
	property p_longest_wins;
		@(posedge ref_clk_i) disable iff (!resetn_i)
		g.load |=> (hold_cnt >= $past(g.load_value));
	endproperty
	a_longest_wins: assert property (p_longest_wins) else $error("guard lost a longer delay");

	property p_burst_kept;
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(burst_cnt > 8'h02) && !g.burst_load |=> g.burst_busy ##1 g.burst_busy;
	endproperty
	a_burst_kept: assert property (p_burst_kept) else $error("burst ended early");

endmodule : pdc_cke_guard
`default_nettype wire

// ---- hdl/pdc_power_ctl.sv ----
// pdc_power_ctl: power-state and clock-management tracker of the memory device.
// assumes: pins sampled on the rising edge of ref_clk_i; clock health and clock
// restart are reported by the clock front end on clk_valid_i and clk_resume_i.
// Summary of operation
// - enable low, select low, 011 enters deep sleep
// - deep sleep loses stored contents
// - enable high leaves deep sleep, reinit
// - ready after two cycles plus exit latency
// - no-op needs constant enable, two encodings
// - no-op never aborts running operation
`timescale 1ns/100ps
`default_nettype none
module pdc_power_ctl (
	input  wire logic                          ref_clk_i,
	input  wire logic                          resetn_i,
	input  wire logic                          cke_i,
	input  wire logic                          cs_n_i,
	input  wire logic                          cmd_bit0_i,
	input  wire logic                          cmd_bit1_i,
	input  wire logic                          cmd_bit2_i,
	input  wire logic                          cmd_bit3_i,
	input  wire logic                          auto_pre_i,
	input  wire logic [pdc_pkg::LAT_W-1:0]     read_latency_i,
	input  wire logic [pdc_pkg::LAT_W-1:0]     write_latency_i,
	input  wire logic [pdc_pkg::BURST_W-1:0]   burst_length_i,
	input  wire logic                          clk_valid_i,
	input  wire logic                          clk_resume_i,
	input  wire logic                          init_done_i,
	output logic                               ready_o,
	output logic                               power_down_o,
	output logic                               deep_sleep_o,
	output logic                               array_power_o,
	output logic                               data_lost_o,
	output logic                               init_required_o,
	output logic                               illegal_o,
	output logic                               nop_o,
	output var pdc_pkg::pdc_cmd_type           cmd_code_o,
	output logic                               cke_guard_busy_o,
	output logic                               burst_busy_o
);
	import pdc_pkg::*;

	localparam int RESTART_DLY = int'(RESTART_CYC);

	pdc_guard_if guard_bus ();

	pdc_state_type       state;
	pdc_state_type       next_state;
	pdc_cmd_type         dec;
	pdc_cmd_type         next_cmd_code;
	logic [CMD_W-1:0]    cmd_bits;
	logic                cke_prev;
	logic                next_cke_prev;
	logic                nop_now;
	logic                next_nop;
	logic                dpd_first;
	logic                next_dpd_first;
	logic                init_required;
	logic                next_init_required;
	logic                data_lost;
	logic                next_data_lost;
	logic                illegal;
	logic                next_illegal;
	logic                illegal_set;
	logic                cke_fall;
	logic [CNT_W-1:0]    wait_cnt;
	logic [CNT_W-1:0]    next_wait_cnt;
	logic [CNT_W-1:0]    settle_cnt;
	logic [CNT_W-1:0]    next_settle_cnt;
	logic [CNT_W-1:0]    low_age;
	logic [CNT_W-1:0]    next_low_age;
	logic [CNT_W-1:0]    half_burst;
	logic                pdc_cmd_nop_out;

	// ==========================================================================
	// command decode
	assign cmd_bits   = {cmd_bit3_i, cmd_bit2_i, cmd_bit1_i, cmd_bit0_i};
	assign dec        = pdc_decode(cke_prev, cke_i, cs_n_i, cmd_bits);
	assign cke_fall   = cke_prev && !cke_i;
	assign half_burst = CNT_W'(burst_length_i >> 1);
	// held-low cycles count as no-op in either encoding; a changing enable never does
	assign nop_now    = (dec == cmd_nop)
	                  || ((dec == cmd_hold) && (cs_n_i || (cmd_bits[2:0] == 3'h7)));

	// ==========================================================================
	// delay loads for the clock-enable guard, only from the normal state
	always_comb begin
		guard_bus.load        = (state == st_normal);
		guard_bus.load_value  = '0;
		guard_bus.burst_load  = (state == st_normal);
		guard_bus.burst_value = '0;
		case (dec)
			cmd_rd, cmd_mrr: begin
				guard_bus.load_value = CNT_W'(read_latency_i + STROBE_ACCESS_CYC
				                       + half_burst + EXTRA_CYC);
				guard_bus.burst_value = CNT_W'(read_latency_i + half_burst);
			end
			cmd_wr: begin
				// auto-precharge adds one cycle after recovery
				guard_bus.load_value = CNT_W'(write_latency_i + EXTRA_CYC + half_burst
				                       + WRITE_RECOVERY_CYC
				                       + (auto_pre_i ? EXTRA_CYC : 8'h00));
				guard_bus.burst_value = CNT_W'(write_latency_i + half_burst);
			end
			cmd_ref_one, cmd_ref_all, cmd_act, cmd_pre: begin
				guard_bus.load_value = CLK_EN_HOLD_CYC;
			end
			cmd_mrw: begin
				guard_bus.load_value = MODE_WRITE_CYC;
			end
			default: begin
				guard_bus.load       = 1'b0;
				guard_bus.burst_load = 1'b0;
			end
		endcase
	end

	pdc_cke_guard u_guard (
		.ref_clk_i (ref_clk_i),
		.resetn_i  (resetn_i),
		.g         (guard_bus.guard)
	);

	// ==========================================================================
	// power state machine and violation detection
	always_comb begin
		next_state         = state;
		next_cke_prev      = cke_i;
		next_cmd_code      = dec;
		next_nop           = nop_now;
		next_dpd_first     = 1'b0;
		next_wait_cnt      = wait_cnt;
		next_data_lost     = data_lost;
		illegal_set        = 1'b0;
		// consecutive healthy clock cycles, saturating
		next_settle_cnt = !clk_valid_i ? '0
		                : (settle_cnt < CLOCK_SETTLE_CYC) ? settle_cnt + 8'h01 : settle_cnt;
		next_low_age = cke_fall ? '0
		             : (low_age < CLOCK_SETTLE_CYC) ? low_age + 8'h01 : low_age;
		case (state)
			st_normal: begin
				if (dec == cmd_bad) begin
					illegal_set = 1'b1;
				end
				if (cke_fall && guard_bus.hold_busy) begin
					illegal_set = 1'b1;
				end
				if (init_required && ((dec == cmd_rd) || (dec == cmd_wr) || (dec == cmd_act))) begin
					illegal_set = 1'b1;
				end
				// a clock change with enable high must keep the device deselected
				if (cke_i && !clk_valid_i && !cs_n_i) begin
					illegal_set = 1'b1;
				end
				if (dec == cmd_dpd_entry) begin
					next_state     = st_deep_sleep;
					next_dpd_first = 1'b1;
					next_data_lost = 1'b1;
				end else if ((dec == cmd_pd_entry) || (dec == cmd_sref_entry)) begin
					next_state = st_power_down;
				end else if (clk_resume_i && nop_now) begin
					next_state    = st_wait_ready;
					next_wait_cnt = RESTART_CYC;
				end
			end
			st_power_down: begin
				// the original clock must run two cycles after the drop
				if (!clk_valid_i && (low_age < CLOCK_SETTLE_CYC)) begin
					illegal_set = 1'b1;
				end
				if (cke_i) begin
					if (!cs_n_i || (settle_cnt < CLOCK_SETTLE_CYC)) begin
						illegal_set = 1'b1;
					end
					next_state    = st_wait_ready;
					next_wait_cnt = POWERDOWN_EXIT_CYC;
				end
			end
			st_deep_sleep: begin
				if (dpd_first && !nop_now) begin
					illegal_set = 1'b1;
				end
				if (!clk_valid_i && (low_age < CLOCK_SETTLE_CYC)) begin
					illegal_set = 1'b1;
				end
				// any rise of enable ends deep sleep, so enable low is what holds it
				if (cke_i) begin
					if (settle_cnt < CLOCK_SETTLE_CYC) begin
						illegal_set = 1'b1;
					end
					next_state = st_normal;
				end
			end
			st_wait_ready: begin
				if (!nop_now) begin
					illegal_set = 1'b1;
				end
				if (wait_cnt <= 8'h01) begin
					next_state = st_normal;
				end else begin
					next_wait_cnt = wait_cnt - 8'h01;
				end
			end
			default: begin
				next_state = st_normal;
			end
		endcase
		// set wins over the clear from a finished initialisation
		next_illegal       = illegal_set || (illegal && !init_done_i);
		next_init_required = illegal_set || (next_state == st_deep_sleep && state != st_deep_sleep)
		                   || (init_required && !init_done_i);
		if (init_done_i && !next_data_lost_set(state, dec)) begin
			next_data_lost = 1'b0;
		end
	end

	// deep sleep entry keeps contents marked lost even against init_done
	function automatic logic next_data_lost_set(input pdc_state_type s, input pdc_cmd_type c);
		return (s == st_normal) && (c == cmd_dpd_entry);
	endfunction : next_data_lost_set

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			state         <= st_power_down;
			cke_prev      <= CKE_PREV_RST;
			cmd_code_o    <= cmd_hold;
			pdc_cmd_nop_out <= 1'b0;
			dpd_first     <= 1'b0;
			wait_cnt      <= '0;
			settle_cnt    <= '0;
			low_age       <= '0;
			data_lost     <= DATA_LOST_RST;
			init_required <= INIT_REQUIRED_RST;
			illegal       <= ILLEGAL_RST;
		end else begin
			state         <= next_state;
			cke_prev      <= next_cke_prev;
			cmd_code_o    <= next_cmd_code;
			pdc_cmd_nop_out <= next_nop;
			dpd_first     <= next_dpd_first;
			wait_cnt      <= next_wait_cnt;
			settle_cnt    <= next_settle_cnt;
			low_age       <= next_low_age;
			data_lost     <= next_data_lost;
			init_required <= next_init_required;
			illegal       <= next_illegal;
		end
	end

	// ==========================================================================
	// outputs; internal supply is cut only in deep sleep
	assign ready_o          = (state == st_normal);
	assign power_down_o     = (state == st_power_down);
	assign deep_sleep_o     = (state == st_deep_sleep);
	assign array_power_o    = (state != st_deep_sleep);
	assign data_lost_o      = data_lost;
	assign init_required_o  = init_required;
	assign illegal_o        = illegal;
	assign nop_o            = pdc_cmd_nop_out;
	assign cke_guard_busy_o = guard_bus.hold_busy;
	assign burst_busy_o     = guard_bus.burst_busy;

	// ==========================================================================
	// checks
	property p_dpd_entry;
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(state == st_normal) && cke_prev && !cke_i && !cs_n_i && (cmd_bits[2:0] == 3'h3)
		|=> deep_sleep_o && !array_power_o;
	endproperty
	a_dpd_entry: assert property (p_dpd_entry) else $error("deep sleep not entered");

	property p_data_lost;
		@(posedge ref_clk_i) disable iff (!resetn_i)
		deep_sleep_o |-> data_lost_o && init_required_o;
	endproperty
	a_data_lost: assert property (p_data_lost) else $error("contents not marked lost");

	property p_dpd_exit;
		@(posedge ref_clk_i) disable iff (!resetn_i)
		deep_sleep_o && cke_i && !init_done_i |=> ready_o && init_required_o;
	endproperty
	a_dpd_exit: assert property (p_dpd_exit) else $error("deep sleep exit wrong");

	property p_restart_ready;
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(state == st_normal) && clk_resume_i && nop_now
		|=> !ready_o ##[RESTART_DLY:RESTART_DLY] ready_o;
	endproperty
	a_restart_ready: assert property (p_restart_ready) else $error("restart wait wrong");

	property p_nop_const;
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(cke_prev != cke_i) |=> !nop_o;
	endproperty
	a_nop_const: assert property (p_nop_const) else $error("no-op with enable change");

	property p_cke_guard;
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(state == st_normal) && cke_fall && cke_guard_busy_o |=> illegal_o;
	endproperty
	a_cke_guard: assert property (p_cke_guard) else $error("early enable drop missed");

	property p_illegal_hold;
		@(posedge ref_clk_i) disable iff (!resetn_i)
		illegal_o && !init_done_i |=> illegal_o && init_required_o;
	endproperty
	a_illegal_hold: assert property (p_illegal_hold) else $error("illegal flag dropped");

	property p_nop_after_dpd;
		@(posedge ref_clk_i) disable iff (!resetn_i)
		deep_sleep_o && dpd_first && !nop_now |=> illegal_o;
	endproperty
	a_nop_after_dpd: assert property (p_nop_after_dpd) else $error("missing no-op missed");

	property p_settle;
		@(posedge ref_clk_i) disable iff (!resetn_i)
		deep_sleep_o && cke_i && (settle_cnt < CLOCK_SETTLE_CYC) |=> illegal_o;
	endproperty
	a_settle: assert property (p_settle) else $error("unsettled exit missed");

endmodule : pdc_power_ctl
`default_nettype wire

// ---- test/pdc_ctl_model.sv ----
// pdc_ctl_model: memory controller stand-in driving enable, select and command bits
// assumes: the bench calls drive once per cycle, shared clock with the tracker
`timescale 1ns/100ps
`default_nettype none
module pdc_ctl_model (
	input  wire logic  ref_clk_i,
	output logic       cke_o,
	output logic       cs_n_o,
	output logic [3:0] cmd_o
);
	// ==========================================================================
	// pin driver
	// pins move just after the edge; deselected bits toggle so a stale code never passes
	task automatic drive(input logic ke, input logic cs, input logic [3:0] c);
		@(posedge ref_clk_i);
		cke_o  <= ke;
		cs_n_o <= cs;
		cmd_o  <= cs ? ~cmd_o : c;
	endtask : drive

	// powered up with enable low and the device deselected
	initial begin
		cke_o  = 1'b0;
		cs_n_o = 1'b1;
		cmd_o  = 4'h7;
	end
endmodule : pdc_ctl_model
`default_nettype wire

// ---- test/tb_top.sv ----
// tb_top: self-checking bench for the power-state tracker
// assumes: pdc_ctl_model drives the pins; clock valid stays high except one glitch near the end
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import pdc_pkg::*;
	logic        ref_clk_i = 1'b0;
	logic        resetn_i  = 1'b0;
	// clock kept healthy except one deliberate glitch; one drop follows an activate with no precharge between
	logic        valid     = 1'b1;
	logic        resume    = 1'b0;
	logic        done      = 1'b0;
	logic        ap        = 1'b0;
	logic [3:0]  rl        = 4'h1;
	logic [3:0]  wl        = 4'h1;
	logic [4:0]  bl        = 5'h04;
	logic [31:0] seed      = 32'h989d;
	logic        cke, cs_n, ready, pd, ds, apw, lost, ini, ill, nop, gbusy, bbusy;
	logic [3:0]  cmd;
	pdc_cmd_type code;
	int          bad_count, n_compared, r, w, b, n;
	logic [3:0]  ops [9] = '{4'h5, 4'h8, 4'h1, 4'h1, 4'h0, 4'h4, 4'hc, 4'h2, 4'hb};

	pdc_ctl_model i_ctl (.ref_clk_i(ref_clk_i), .cke_o(cke), .cs_n_o(cs_n), .cmd_o(cmd));
	pdc_power_ctl i_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cke_i(cke),
		.cs_n_i(cs_n), .cmd_bit0_i(cmd[0]), .cmd_bit1_i(cmd[1]), .cmd_bit2_i(cmd[2]),
		.cmd_bit3_i(cmd[3]), .auto_pre_i(ap), .read_latency_i(rl), .write_latency_i(wl),
		.burst_length_i(bl), .clk_valid_i(valid), .clk_resume_i(resume),
		.init_done_i(done), .ready_o(ready), .power_down_o(pd), .deep_sleep_o(ds),
		.array_power_o(apw), .data_lost_o(lost), .init_required_o(ini), .illegal_o(ill),
		.nop_o(nop), .cmd_code_o(code), .cke_guard_busy_o(gbusy), .burst_busy_o(bbusy));

	// ==========================================================================
	// helpers
	initial begin
		forever #25 ref_clk_i = ~ref_clk_i;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs

	// cycles from command edge until enable may be sampled low
	function automatic int expn(input int i, input int rd, input int wr, input int bu);
		case (i)
			0, 1: return rd + STROBE_ACCESS_CYC + bu / 2 + 1;
			2, 3: return wr + 1 + bu / 2 + WRITE_RECOVERY_CYC + (i == 3);
			4: return MODE_WRITE_CYC;
			default: return CLK_EN_HOLD_CYC;
		endcase
	endfunction : expn

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// one pin cycle; side pulses ride the same edge, then look once updates landed
	task automatic cyc(input logic ke, input logic cs, input logic [3:0] c,
	                   input logic [1:0] x);
		i_ctl.drive(ke, cs, c);
		resume <= x[1];
		done   <= x[0];
		#1;
	endtask : cyc

	// two settled low cycles, then exit with select high; deep sleep exit has no wait cycle
	task automatic wake(input logic fast);
		cyc(1'b0, 1'b1, 4'h7, 2'h0);
		cyc(1'b0, 1'b1, 4'h7, 2'h0);
		cyc(1'b1, 1'b1, 4'h7, 2'h0);
		cyc(1'b1, 1'b1, 4'h7, 2'h0);
		chk(ready, 8'(fast));
		cyc(1'b1, 1'b1, 4'h7, 2'h0);
		chk(ready, 1'b1);
	endtask : wake

	task automatic clear();
		cyc(1'b1, 1'b1, 4'h7, 2'h1);
		cyc(1'b1, 1'b1, 4'h7, 2'h0);
		chk({lost, ini, ill}, 3'h0);
	endtask : clear

	// command, wt no-op cycles, then enable drop; early drops must be flagged
	task automatic hold(input logic [3:0] c, input int wt);
		cyc(1'b1, 1'b0, c, 2'h0);
		for (int i = 1; i <= wt; i++) begin
			cyc(1'b1, 1'b1, 4'h7, 2'h0);
			chk(gbusy, 1'b1);
			if (i == 1) begin
				chk(bbusy, 8'(c[2:0] == 3'h5 || c[2:0] == 3'h1 || c == 4'h8));
			end
		end
		cyc(1'b0, 1'b1, 4'h7, 2'h0);
		chk(gbusy, 8'(wt + 1 < n));
		cyc(1'b0, 1'b1, 4'h7, 2'h0);
		chk(pd, 1'b1);
		chk(ill, 8'(wt + 1 < n));
		wake(1'b0);
	endtask : hold

	// deep sleep entry; fcs low makes the following cycle a real command
	task automatic dsleep(input logic fcs);
		cyc(1'b0, 1'b0, 4'h3, 2'h0);
		cyc(1'b0, fcs, 4'h2, 2'h0);
		chk({ds, apw}, 2'h2);
		cyc(1'b0, 1'b0, 4'hf, 2'h0);
		chk({lost, ini, ds}, 3'h7);
		wake(1'b1);
		chk(ill, 8'(!fcs));
		clear();
	endtask : dsleep

	task automatic results();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results

	// ==========================================================================
	// main sequence; the watchdog counts a hang as a mismatch
	initial begin
		repeat (3000) @(posedge ref_clk_i);
		bad_count++;
		results();
	end

	initial begin
		repeat (4) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		#1;
		chk({pd, ready, ds, apw, lost, ini, ill, nop}, 8'h9c);
		chk(code, cmd_hold);
		wake(1'b0);
		clear();
		cyc(1'b1, 1'b0, 4'hf, 2'h0);
		cyc(1'b1, 1'b1, 4'h0, 2'h0);
		cyc(1'b1, 1'b0, 4'hf, 2'h0);
		chk(code, cmd_nop);
		chk(nop, 1'b1);
		for (int i = 0; i < 9; i++) begin
			seed = xs(seed);
			r = 1 + seed[2:0];
			w = 1 + seed[5:3];
			b = 4 << (seed[7:6] % 3);
			rl <= 4'(r);
			wl <= 4'(w);
			bl <= 5'(b);
			ap <= (i == 3);
			n = expn(i, r, w, b);
			if (i < 4) begin
				hold(ops[i], n - 2);
				clear();
			end
			hold(ops[i], n - 1);
		end
		dsleep(1'b1);
		dsleep(1'b0);
		cyc(1'b1, 1'b1, 4'h7, 2'h2);
		for (int i = 1; i <= 4; i++) begin
			cyc(1'b1, 1'b1, 4'h7, 2'h0);
			chk(ready, 8'(i > RESTART_CYC));
		end
		// selected while the clock is unhealthy with enable high must be flagged
		cyc(1'b1, 1'b0, 4'h7, 2'h0);
		valid <= 1'b0;
		cyc(1'b1, 1'b1, 4'h7, 2'h0);
		valid <= 1'b1;
		cyc(1'b1, 1'b1, 4'h7, 2'h0);
		chk(ill, 1'b1);
		results();
	end
endmodule : tb_top
`default_nettype wire
